// ===== rtl/line_fifo_params.svh
// Purpose: shared constants of the line delay fifo, both ends
// Assumes: host clock at 100 MHz, link clocks divided from it by two
// Notes: timing counts are derived from their times here
//
// How it works
// [RL1] array of 8192 words, 10 bits each
// [RL2] write enable low stores the input word
// [RL3] each stored word advances write counter
// [RL4] write enable high: no store, counter holds
// [RL5] write counter reset returns address to start
// [RL6] read enable low outputs word, advances counter
// [RL7] read enable high: counter holds, outputs float
// [RL8] read counter reset returns address to start
// [RL9] write and read ports run fully independent
// [RL10] writer revisits every location within 20 ms
// [RL11] reset both counters after power up
// [RL12] captured word commits during next write cycle
// [RL13] writer supplies the extra committing clock edge
// [RL14] write at second edge, read at first
// [RL15] short delays come from reset or disable timing
// [RL16] reader lags writer by two cycles minimum
// [RL17] word readable until next line overwrites it
// [RL18] counters start at zero and wrap around
// [RL19] no full or empty flags at all
`ifndef LINE_FIFO_PARAMS_SVH
`define LINE_FIFO_PARAMS_SVH

`define LF_DEPTH 8192
`define LF_ADDR_W 13
`define LF_DATA_W 10
`define LF_ADDR_ZERO 13'h0000
`define LF_ADDR_LAST 13'h1FFF
`define LF_ADDR_ONE 13'h0001
`define LF_DATA_ZERO 10'h000
`define LF_CLOCK_NS 10
`define LF_HOLD_NS 20000000
`define LF_HOLD_CYCLES (`LF_HOLD_NS / `LF_CLOCK_NS)
`define LF_LINK_DIV 2
`define LF_IDLE_W 21
`define LF_IDLE_ZERO 21'h000000
`define LF_IDLE_MAX 21'h1FFFFF

`endif

// ===== rtl/line_fifo_pkg.sv
// Purpose: types shared by both ends of the line delay fifo
// Assumes: constants come from line_fifo_params.svh
// Notes: types only
`include "line_fifo_params.svh"
package line_fifo_pkg;
  typedef logic [`LF_ADDR_W-1:0] addr_t;
  typedef logic [`LF_DATA_W-1:0] word_t;
endpackage

// ===== rtl/line_fifo_if.sv
// Purpose: pins between the line fifo and its controlling logic
// Assumes: host makes both link clocks
// Notes: the shared data wire is resolved here from the enable
`timescale 1ns/1ns
`include "line_fifo_params.svh"
interface line_fifo_if;
  logic write_clock;
  logic write_enable_n;
  logic write_counter_reset_n;
  line_fifo_pkg::word_t write_data_in;
  logic read_clock;
  logic read_enable_n;
  logic read_counter_reset_n;
  line_fifo_pkg::word_t read_data_q;
  logic read_data_oe_n;
  wire [`LF_DATA_W-1:0] read_data_out;

  // a floating bus is modelled as pulled low; only valid reads are used
  assign read_data_out = read_data_oe_n ? `LF_DATA_ZERO : read_data_q;

  modport device (
    input write_clock,
    input write_enable_n,
    input write_counter_reset_n,
    input write_data_in,
    input read_clock,
    input read_enable_n,
    input read_counter_reset_n,
    output read_data_q,
    output read_data_oe_n
  );

  modport host (
    output write_clock,
    output write_enable_n,
    output write_counter_reset_n,
    output write_data_in,
    output read_clock,
    output read_enable_n,
    output read_counter_reset_n,
    input read_data_out
  );
endinterface

// ===== rtl/addr_counter.sv
// Purpose: sequential address counter for one port of the line fifo
// Assumes: clear and step are sampled on the port's own clock
// Notes: clear wins over step
`timescale 1ns/1ns
`include "line_fifo_params.svh"
module addr_counter (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear_n,
  input wire logic step,
  output line_fifo_pkg::addr_t count
);
  line_fifo_pkg::addr_t count_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= `LF_ADDR_ZERO; // RL18
    end else if (!clear_n) begin
      count_ff <= `LF_ADDR_ZERO; // RL5 RL8
    end else if (step) begin
      if (count_ff == `LF_ADDR_LAST) begin
        count_ff <= `LF_ADDR_ZERO; // RL18
      end else begin
        count_ff <= count_ff + `LF_ADDR_ONE; // RL3
      end
    end
  end

  assign count = count_ff;
endmodule

// ===== rtl/line_fifo_device.sv
// Purpose: the line memory itself, write and read on their own clocks
// Assumes: the user's requests keep the lag and refresh limits; the host only warns on refresh
// Notes: no bypass from the commit stage to the read port
`timescale 1ns/1ns
`include "line_fifo_params.svh"
module line_fifo_device (
  line_fifo_if.device link,
  input wire logic rst_n
);
  ////////////////////////////////////////////////////////////////////////
  // storage and counters
  line_fifo_pkg::word_t mem [0:`LF_DEPTH-1]; // RL1
  line_fifo_pkg::addr_t waddr;
  line_fifo_pkg::addr_t raddr;
  logic store;
  logic fetch;

  // a counter reset cycle neither stores nor reads
  assign store = ~link.write_enable_n & link.write_counter_reset_n; // RL2 RL4
  assign fetch = ~link.read_enable_n & link.read_counter_reset_n; // RL6 RL7

  addr_counter u_write_counter (
    .clock(link.write_clock),
    .rst_n(rst_n),
    .clear_n(link.write_counter_reset_n),
    .step(store),
    .count(waddr)
  );

  addr_counter u_read_counter (
    .clock(link.read_clock),
    .rst_n(rst_n),
    .clear_n(link.read_counter_reset_n),
    .step(fetch),
    .count(raddr)
  );

  ////////////////////////////////////////////////////////////////////////
  // write side: capture, then commit one write clock later
  logic commit_ff;
  line_fifo_pkg::addr_t commit_addr_ff;
  line_fifo_pkg::word_t commit_data_ff;

  always_ff @(posedge link.write_clock or negedge rst_n) begin
    if (!rst_n) begin
      commit_ff <= 1'b0;
      commit_addr_ff <= `LF_ADDR_ZERO;
      commit_data_ff <= `LF_DATA_ZERO;
    end else begin
      commit_ff <= store; // RL12
      if (store) begin
        commit_addr_ff <= waddr;
        commit_data_ff <= link.write_data_in;
      end
    end
  end

  // the word lands only at the next edge, so a stopped clock loses it
  always_ff @(posedge link.write_clock) begin
    if (commit_ff) begin
      mem[commit_addr_ff] <= commit_data_ff; // RL12 RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read side: output at the first edge of the read cycle
  line_fifo_pkg::word_t q_ff;
  logic oe_n_ff;

  always_ff @(posedge link.read_clock or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= `LF_DATA_ZERO;
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= ~fetch; // RL7
      if (fetch) begin
        q_ff <= mem[raddr]; // RL6 RL14 RL17
      end
    end
  end

  // nothing here relates the two clocks; there are no fill flags
  assign link.read_data_q = q_ff; // RL9 RL19
  assign link.read_data_oe_n = oe_n_ff;
endmodule

// ===== rtl/line_fifo_host.sv
// Purpose: controlling logic that writes and reads the line fifo
// Assumes: user requests come from logic on clock
// Notes: both link clocks are clock divided by two, running free
`timescale 1ns/1ns
`include "line_fifo_params.svh"
module line_fifo_host #(
  parameter int HOLD_CYCLES = `LF_HOLD_CYCLES
) (
  line_fifo_if.host link,
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_req,
  input wire line_fifo_pkg::word_t wr_data,
  input wire logic wr_restart,
  output logic wr_ready,
  input wire logic rd_req,
  input wire logic rd_restart,
  output logic rd_ready,
  output line_fifo_pkg::word_t rd_data,
  output logic rd_data_valid,
  output logic wr_stale,
  output logic rd_stale
);
  localparam logic [`LF_IDLE_W-1:0] STALE_LIMIT =
    (`LF_IDLE_W)'(HOLD_CYCLES - `LF_DEPTH * `LF_LINK_DIV);

  function automatic logic [`LF_IDLE_W-1:0] sat_inc(
    input logic [`LF_IDLE_W-1:0] v
  );
    return (v == `LF_IDLE_MAX) ? v : v + (`LF_IDLE_W)'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link clock and launch of the pins
  logic phase_ff;
  logic boot_ff;
  logic wen_n_ff;
  logic write_counter_reset_n_n_ff;
  line_fifo_pkg::word_t wdata_ff;
  logic ren_n_ff;
  logic read_counter_reset_n_n_ff;
  logic load;

  // pins change on the falling link edge, half a cycle before sampling
  assign load = phase_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff; // RL13
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_ff <= 1'b1;
    end else if (load) begin
      boot_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wen_n_ff <= 1'b1;
      write_counter_reset_n_n_ff <= 1'b0;
      wdata_ff <= `LF_DATA_ZERO;
      ren_n_ff <= 1'b1;
      read_counter_reset_n_n_ff <= 1'b0;
    end else if (load) begin
      write_counter_reset_n_n_ff <= ~(boot_ff | wr_restart); // RL11 RL15
      read_counter_reset_n_n_ff <= ~(boot_ff | rd_restart); // RL11 RL15
      wen_n_ff <= ~(wr_req & ~boot_ff);
      ren_n_ff <= ~(rd_req & ~boot_ff); // RL15
      if (wr_req) begin
        wdata_ff <= wr_data;
      end
    end
  end

  assign wr_ready = phase_ff & ~boot_ff;
  assign rd_ready = phase_ff & ~boot_ff;
  assign link.write_clock = phase_ff;
  assign link.read_clock = phase_ff;
  assign link.write_enable_n = wen_n_ff;
  assign link.write_counter_reset_n = write_counter_reset_n_n_ff;
  assign link.write_data_in = wdata_ff;
  assign link.read_enable_n = ren_n_ff;
  assign link.read_counter_reset_n = read_counter_reset_n_n_ff;

  ////////////////////////////////////////////////////////////////////////
  // read return: data pins pass two flops, valid follows alongside
  line_fifo_pkg::word_t sync1_ff;
  line_fifo_pkg::word_t sync2_ff;
  logic v0_ff;
  logic v1_ff;
  logic v2_ff;
  line_fifo_pkg::word_t rd_data_ff;
  logic rd_valid_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= `LF_DATA_ZERO;
      sync2_ff <= `LF_DATA_ZERO;
    end else begin
      sync1_ff <= link.read_data_out;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      v0_ff <= 1'b0;
      v1_ff <= 1'b0;
      v2_ff <= 1'b0;
      rd_data_ff <= `LF_DATA_ZERO;
      rd_valid_ff <= 1'b0;
    end else begin
      v0_ff <= ~phase_ff & ~ren_n_ff & read_counter_reset_n_n_ff;
      v1_ff <= v0_ff;
      v2_ff <= v1_ff;
      rd_valid_ff <= v2_ff;
      if (v2_ff) begin
        rd_data_ff <= sync2_ff;
      end
    end
  end

  // lag and overwrite limits stay with the user's request order
  assign rd_data = rd_data_ff; // RL16 RL17
  assign rd_data_valid = rd_valid_ff;

  ////////////////////////////////////////////////////////////////////////
  // refresh watch: warns, does not stop traffic
  logic [`LF_IDLE_W-1:0] wr_idle_ff;
  logic [`LF_IDLE_W-1:0] rd_idle_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_idle_ff <= `LF_IDLE_ZERO;
    end else if (!wen_n_ff || !write_counter_reset_n_n_ff) begin
      wr_idle_ff <= `LF_IDLE_ZERO;
    end else begin
      wr_idle_ff <= sat_inc(wr_idle_ff); // RL10
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_idle_ff <= `LF_IDLE_ZERO;
    end else if (!ren_n_ff || !read_counter_reset_n_n_ff) begin
      rd_idle_ff <= `LF_IDLE_ZERO;
    end else begin
      rd_idle_ff <= sat_inc(rd_idle_ff); // RL10
    end
  end

  assign wr_stale = wr_idle_ff >= STALE_LIMIT; // RL10
  assign rd_stale = rd_idle_ff >= STALE_LIMIT;
endmodule

// ===== tb/line_fifo_checker.sv
// Purpose: link checker for the line fifo
// Assumes: both link clocks come from the host
// Notes: shadow memory scores only words it saw stored
`timescale 1ns/1ns
module line_fifo_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic write_clock,
  input wire logic write_enable_n,
  input wire logic write_counter_reset_n,
  input wire line_fifo_pkg::word_t write_data_in,
  input wire logic read_clock,
  input wire logic read_enable_n,
  input wire logic read_counter_reset_n,
  input wire line_fifo_pkg::word_t read_data_q,
  input wire logic read_data_oe_n
);
  line_fifo_pkg::word_t mem [8192];
  logic [8191:0] seen_ff;
  line_fifo_pkg::addr_t waddr_ff;
  line_fifo_pkg::addr_t raddr_ff;
  line_fifo_pkg::word_t exp_ff;
  logic exp_ok_ff;
  ////////////////////////////////////////
  always_ff @(posedge write_clock or negedge rst_n) begin
    if (!rst_n) begin
      waddr_ff <= 13'h0000;
      seen_ff <= '0;
    end else if (!write_counter_reset_n) begin
      waddr_ff <= 13'h0000;
    end else if (!write_enable_n) begin
      mem[waddr_ff] <= write_data_in;
      seen_ff[waddr_ff] <= 1'b1;
      waddr_ff <= waddr_ff + 13'h0001;
    end
  end
  // same-edge read sees old contents, as the device does
  always_ff @(posedge read_clock or negedge rst_n) begin
    if (!rst_n) begin
      raddr_ff <= 13'h0000;
      exp_ok_ff <= 1'b0;
    end else if (!read_counter_reset_n) begin
      raddr_ff <= 13'h0000;
      exp_ok_ff <= 1'b0;
    end else begin
      exp_ok_ff <= !read_enable_n && seen_ff[raddr_ff];
      if (!read_enable_n) begin
        exp_ff <= mem[raddr_ff];
        raddr_ff <= raddr_ff + 13'h0001;
      end
    end
  end
  ////////////////////////////////////////
  chk_read_word: assert property (
    @(posedge read_clock) disable iff (!rst_n)
    exp_ok_ff |-> read_data_q == exp_ff) else $error("read word wrong");
  chk_drive_read: assert property (
    @(posedge read_clock) disable iff (!rst_n)
    (!read_enable_n && read_counter_reset_n) |=> !read_data_oe_n)
    else $error("output not driven on read");
  chk_float_idle: assert property (
    @(posedge read_clock) disable iff (!rst_n)
    read_enable_n |=> read_data_oe_n) else $error("output driven idle");
  chk_float_reset: assert property (
    @(posedge read_clock) disable iff (!rst_n)
    !read_counter_reset_n |=> read_data_oe_n)
    else $error("output driven in reset");
  chk_q_holds: assert property (
    @(posedge read_clock) disable iff (!rst_n)
    (read_enable_n && read_counter_reset_n) |=> $stable(read_data_q))
    else $error("output word moved");
  chk_clock_toggle: assert property (
    @(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> write_clock != $past(write_clock))
    else $error("link clock stalled");
  chk_wdata_setup: assert property (
    @(posedge clock) disable iff (!rst_n)
    $changed(write_data_in) |-> !write_clock)
    else $error("write data moved near rise");
  chk_ren_setup: assert property (
    @(posedge clock) disable iff (!rst_n)
    $changed(read_enable_n) |-> !read_clock)
    else $error("read enable moved near rise");
endmodule

// ===== tb/tb_top.sv
// Purpose: drives the line fifo pair from the user side
// Assumes: hold limit shortened to 20000 clocks
// Notes: a monitor gathers returned words for each test
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wr_req = 1'b0;
  logic wr_restart = 1'b0;
  logic rd_req = 1'b0;
  logic rd_restart = 1'b0;
  line_fifo_pkg::word_t wr_data = 10'h000;
  logic wr_ready, rd_ready, rd_data_valid, wr_stale, rd_stale;
  line_fifo_pkg::word_t rd_data;
  line_fifo_pkg::word_t got [$];
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  line_fifo_if lnk();
  line_fifo_device i_line_fifo_device (.link(lnk.device), .rst_n(rst_n));
  line_fifo_host #(.HOLD_CYCLES(20000)) i_line_fifo_host (
    .link(lnk.host), .clock(clock), .rst_n(rst_n), .wr_req(wr_req),
    .wr_data(wr_data), .wr_restart(wr_restart), .wr_ready(wr_ready),
    .rd_req(rd_req), .rd_restart(rd_restart), .rd_ready(rd_ready),
    .rd_data(rd_data), .rd_data_valid(rd_data_valid),
    .wr_stale(wr_stale), .rd_stale(rd_stale));
  line_fifo_checker i_line_fifo_checker (.clock(clock), .rst_n(rst_n),
    .write_clock(lnk.write_clock), .write_enable_n(lnk.write_enable_n),
    .write_counter_reset_n(lnk.write_counter_reset_n),
    .write_data_in(lnk.write_data_in), .read_clock(lnk.read_clock),
    .read_enable_n(lnk.read_enable_n),
    .read_counter_reset_n(lnk.read_counter_reset_n),
    .read_data_q(lnk.read_data_q), .read_data_oe_n(lnk.read_data_oe_n));
  ////////////////////////////////////////
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (rd_data_valid === 1'b1) got.push_back(rd_data);
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_w(input line_fifo_pkg::word_t a, e);
    cmp_count++;
    if (a !== e) begin
      n_mismatch++;
      $display("[ERR] %0t word %h expected %h", $time, a, e);
    end
  endtask
  task automatic chk_b(input logic a, e);
    cmp_count++;
    if (a !== e) begin
      n_mismatch++;
      $display("[ERR] %0t flag %b expected %b", $time, a, e);
    end
  endtask
  // c is {write, read, write restart, read restart}; one load per call
  task automatic op(input logic [3:0] c, input line_fifo_pkg::word_t d);
    @(negedge clock);
    while (wr_ready !== 1'b0) @(negedge clock);
    @(posedge clock);
    {wr_req, rd_req, wr_restart, rd_restart} <= c;
    wr_data <= d;
    @(posedge clock);
    {wr_req, rd_req, wr_restart, rd_restart} <= 4'h0;
  endtask
  ////////////////////////////////////////
  task automatic t_stream;
    got.delete();
    op(4'h3, 10'h000);
    for (int i = 0; i < 10; i++) begin
      op({i < 8, i >= 2, 2'h0}, line_fifo_pkg::word_t'(10'h3A0 + i));
    end
    repeat (8) @(negedge clock);
    for (int k = 0; k < 8; k++) begin
      chk_w(got[k], line_fifo_pkg::word_t'(10'h3A0 + k));
    end
    $display("stream test done");
  endtask
  task automatic t_hold;
    got.delete();
    op(4'h3, 10'h000);
    for (int i = 0; i < 4; i++) begin
      op(4'h8, line_fifo_pkg::word_t'(10'h155 + i));
      op(4'h0, 10'h2AA);
    end
    for (int i = 0; i < 4; i++) begin
      op(4'h4, 10'h000);
      op(4'h0, 10'h000);
    end
    repeat (8) @(negedge clock);
    chk_b(lnk.read_data_oe_n, 1'b1);
    chk_w(lnk.read_data_out, 10'h000);
    for (int k = 0; k < 4; k++) begin
      chk_w(got[k], line_fifo_pkg::word_t'(10'h155 + k));
    end
    $display("hold test done");
  endtask
  task automatic t_restart;
    got.delete();
    op(4'h3, 10'h000);
    for (int i = 0; i < 3; i++) op(4'h8, line_fifo_pkg::word_t'(10'h100 + i));
    // restart in the same load as a write must not store it
    op(4'hA, 10'h3FF);
    op(4'h8, 10'h0C3);
    op(4'h1, 10'h000);
    for (int i = 0; i < 3; i++) op(4'h4, 10'h000);
    repeat (8) @(negedge clock);
    chk_w(got[0], 10'h0C3);
    chk_w(got[1], 10'h101);
    chk_w(got[2], 10'h102);
    $display("restart test done");
  endtask
  task automatic t_wrap;
    got.delete();
    op(4'h3, 10'h000);
    for (int i = 0; i < 8196; i++) op(4'hC, line_fifo_pkg::word_t'(i));
    repeat (8) @(negedge clock);
    for (int k = 0; k < 4; k++) begin
      chk_w(got[8192 + k], line_fifo_pkg::word_t'(k));
    end
    $display("wrap test done");
  endtask
  task automatic t_stale;
    logic lvl;
    @(negedge clock);
    lvl = rd_ready;
    @(negedge clock);
    chk_b(rd_ready, ~lvl);
    chk_b(wr_ready, rd_ready);
    chk_b(wr_stale, 1'b0);
    repeat (3700) @(negedge clock);
    chk_b(wr_stale, 1'b1);
    chk_b(rd_stale, 1'b1);
    op(4'hC, 10'h000);
    repeat (6) @(negedge clock);
    chk_b(wr_stale, 1'b0);
    chk_b(rd_stale, 1'b0);
    $display("stale test done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    t_stream();
    t_hold();
    t_restart();
    t_wrap();
    t_stale();
    test_done();
  end
endmodule
